// File: bench/bulk_erase_flash_write_port_tb.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: short pulse counts; device model on the far side
// Notes:   undriven data pins toggle so a float never reads as data
`timescale 1ns/1ps
`default_nettype none
module bulk_erase_flash_write_port_tb;
  import flash_host_pkg::*;
  localparam int         PCYC = 20;
  localparam int         ECYC = 50;
  localparam logic [7:0] ERC  = 8'h5A;
  localparam logic [7:0] PGC  = 8'hA5;
  logic        i_sys_clk, i_reset, i_vpp_req, i_req_valid;
  req_type     i_req;
  logic        o_req_ready, o_rsp_valid, o_rsp_err, o_vpp_high;
  logic        o_data_io_oe, dev_drive;
  logic [7:0]  o_rsp_data, o_data_io_o, dev_data, data_bus;
  logic [7:0]  last_bus = 8'h00;
  pins_type    o_pins;
  int          err_total, checks_done, lat;
  logic [31:0] seed;
  int          ref_mem[int];
  int          addr_q[$];
  // ************************************************************
  // Clock, design, device and shared data pins
  // ************************************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  flash_host_ctrl #(.ERASE_CYC(ECYC), .PROG_CYC(PCYC)) dut_u (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_vpp_req(i_vpp_req),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .o_rsp_err(o_rsp_err), .o_vpp_high(o_vpp_high), .o_pins(o_pins),
    .o_data_io_o(o_data_io_o), .o_data_io_oe(o_data_io_oe),
    .i_data_io_i(data_bus));
  flash_dev_model #(.ERASE_CODE(ERC), .PROG_CODE(PGC)) dev_u (
    .i_cs_n(o_pins.chip_sel_n), .i_oe_n(o_pins.out_en_n),
    .i_we_n(o_pins.wr_en_n), .i_vpp(o_vpp_high),
    .i_addr(o_pins.byte_addr), .i_data(data_bus), .o_data(dev_data),
    .o_drive(dev_drive));
  // Released pins show the inverse of the last level each cycle
  assign data_bus = o_data_io_oe ? o_data_io_o :
                    (dev_drive ? dev_data : ~last_bus);
  always @(posedge i_sys_clk) last_bus <= data_bus;
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic summarize();
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // One request, held until taken, then waits for its response
  task automatic do_req(input op_type op, input logic [14:0] a,
                        input logic [7:0] d, input logic [7:0] c);
    int n;
    i_req = '{op, a, d, c};
    i_req_valid = 1'b1;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_req_ready !== 1'b1 && n < 50);
    #1 i_req_valid = 1'b0;
    lat = 0;
    // A refused request answers on the same edge that takes it: look first
    while (o_rsp_valid !== 1'b1 && lat < 1000) begin
      @(posedge i_sys_clk);
      #1 lat++;
    end
    if (lat >= 1000 || n >= 50) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic rd(input logic [14:0] a);
    do_req(OP_READ, a, 8'h00, 8'h00);
    check(o_rsp_data, ref_mem.exists(a) ? ref_mem[a][7:0] : 8'hFF);
  endtask
  // Pin legality every cycle: write only with cs low, oe high, vpp up
  always @(posedge i_sys_clk) begin
    if (!i_reset) begin
      check({7'h0, !o_pins.wr_en_n && (o_pins.chip_sel_n ||
             !o_pins.out_en_n || !o_vpp_high)}, 8'h00);
      check({7'h0, o_data_io_oe && !o_pins.out_en_n}, 8'h00);
      check({7'h0, o_req_ready && !o_pins.chip_sel_n}, 8'h00);
    end
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    seed = 32'd33;
    err_total = 0;
    checks_done = 0;
    i_reset = 1'b1;
    i_vpp_req = 1'b0;
    i_req_valid = 1'b0;
    i_req = '0;
    repeat (4) @(posedge i_sys_clk);
    #1 i_reset = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    // Program with voltage low is refused and leaves the array alone
    do_req(OP_PROG, 15'h0123, 8'h00, PGC);
    check({7'h0, o_rsp_err}, 8'h01);
    rd(15'h0123);
    i_vpp_req = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    #1 check({7'h0, o_vpp_high}, 8'h01);
    addr_q = '{15'h7FFF, 15'h0000};
    repeat (4) addr_q.push_back(int'(rnd() & 32'h7FFF));
    // Two-cycle program of boundary and random bytes, back to back
    foreach (addr_q[i]) begin
      ref_mem[addr_q[i]] = int'(rnd() & 32'hFF);
      do_req(OP_PROG, addr_q[i][14:0], ref_mem[addr_q[i]][7:0], PGC);
      check({7'h0, o_rsp_err}, 8'h00);
      check({7'h0, lat >= PCYC}, 8'h01);
    end
    foreach (addr_q[i]) rd(addr_q[i][14:0]);
    // Lone non-command write changes nothing
    do_req(OP_WRITE, addr_q[0][14:0], 8'h00, 8'h00);
    rd(addr_q[0][14:0]);
    // Bulk erase clears every location
    do_req(OP_ERASE, 15'h0000, 8'h00, ERC);
    check({7'h0, lat >= ECYC}, 8'h01);
    ref_mem.delete();
    foreach (addr_q[i]) rd(addr_q[i][14:0]);
    // Voltage dropped again: program refused
    i_vpp_req = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1 do_req(OP_PROG, addr_q[2][14:0], 8'h3C, PGC);
    check({7'h0, o_rsp_err}, 8'h01);
    rd(addr_q[2][14:0]);
    summarize();
  end
endmodule
`default_nettype wire

// File: bench/flash_dev_model.sv
// Purpose: behavioural byte-wide bulk-erase flash facing the host block
// Assumes: command codes are bench parameters, not fixed device values
// Notes:   stop timer is ideal, so each pulse ends as soon as it starts
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] ERASE_CODE = 8'h5A,
  parameter logic [7:0] PROG_CODE  = 8'hA5
) (
  input  wire logic        i_cs_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_vpp,
  input  wire logic [14:0] i_addr,
  input  wire logic [7:0]  i_data,
  output var  logic [7:0]  o_data,
  output var  logic        o_drive
);
  logic [7:0]  mem [0:32767];
  logic [14:0] addr_lat;
  logic        wr_act = 1'b0;
  logic [1:0]  armed  = 2'h0;
  // ************************************************************
  // Array and read path
  // ************************************************************
  // Shipped erased
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'hFF;
    end
  end
  // Buffers on only for a selected read, else released
  assign o_drive = !i_cs_n && !i_oe_n;
  assign o_data  = mem[i_addr];
  // ************************************************************
  // Command register
  // ************************************************************
  // Address latched at whichever strobe falls last
  always @(negedge i_we_n or negedge i_cs_n) begin
    if (!i_we_n && !i_cs_n && i_oe_n && i_vpp) begin
      addr_lat = i_addr;
      wr_act = 1'b1;
    end
  end
  // Data latched at the first rising strobe; drives the state machine
  always @(posedge i_we_n or posedge i_cs_n) begin
    if (wr_act) begin
      wr_act = 1'b0;
      if (!i_vpp) begin
        armed = 2'h0;
      end else if (armed == 2'h2) begin
        mem[addr_lat] = i_data;
        armed = 2'h0;
      end else if (armed == 2'h1 && i_data == ERASE_CODE) begin
        for (int i = 0; i < 32768; i++) begin
          mem[i] = 8'hFF;
        end
        armed = 2'h0;
      end else if (i_data == ERASE_CODE) begin
        armed = 2'h1;
      end else if (i_data == PROG_CODE) begin
        armed = 2'h2;
      end else begin
        armed = 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// File: design/flash_host_ctrl.sv
// Purpose: host-side sequencer that drives a byte-wide bulk-erase flash
// Assumes: single 50 MHz clock; flash data pins returned through three flops
// Notes:   read, single command write, two-cycle program and erase sequences
`timescale 1ns/1ps
`default_nettype none

module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_PULSE_CYC,
  parameter int PROG_CYC  = PROG_PULSE_CYC
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  input  wire logic              i_vpp_req,
  input  wire logic              i_req_valid,
  input  wire req_type           i_req,
  output var  logic              o_req_ready,
  output var  logic              o_rsp_valid,
  output var  logic [DATA_W-1:0] o_rsp_data,
  output var  logic              o_rsp_err,
  output var  logic              o_vpp_high,
  output var  pins_type          o_pins,
  output var  logic [DATA_W-1:0] o_data_io_o,
  output var  logic              o_data_io_oe,
  input  wire logic [DATA_W-1:0] i_data_io_i
);

  localparam int TW = 26;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_STRB  = 3'b010,
    ST_HOLD  = 3'b011,
    ST_WAIT  = 3'b100,
    ST_DONE  = 3'b101
  } state_type;

  state_type         state;
  req_type           cur;
  logic              second;      // Second cycle of a two-cycle sequence
  logic [3:0]        phase_cnt;
  logic [DATA_W-1:0] sync1;
  logic [DATA_W-1:0] sync2;
  logic [DATA_W-1:0] sync3;
  logic              tmr_load;
  logic              tmr_busy;
  logic              tmr_done;
  logic [TW-1:0]     tmr_count;

  // Is the current request a bus write (command cycle)
  function automatic logic is_wr(input op_type op);
    return op != OP_READ;
  endfunction

  // Does this op need a second cycle followed by a pulse wait
  function automatic logic is_two(input op_type op);
    return (op == OP_PROG) || (op == OP_ERASE);
  endfunction

  // ************************************************************
  // Programming voltage qualifier
  // ************************************************************
  // Dropped only while idle so a running pulse never loses its supply
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_vpp_high <= 1'b0;
    end else if (state == ST_IDLE) begin
      o_vpp_high <= i_vpp_req;
    end
  end

  // ************************************************************
  // Read data synchroniser
  // ************************************************************
  // Three stages; the first is read only by the second
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= i_data_io_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state       <= ST_IDLE;
      cur         <= '0;
      second      <= 1'b0;
      phase_cnt   <= '0;
      o_req_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= '0;
      o_rsp_err   <= 1'b0;
      tmr_load    <= 1'b0;
      tmr_count   <= '0;
    end else begin
      o_rsp_valid <= 1'b0;
      tmr_load    <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_req_ready <= 1'b1;
          if (i_req_valid && o_req_ready) begin
            o_req_ready <= 1'b0;
            if (is_wr(i_req.op) && !o_vpp_high) begin
              o_rsp_err   <= 1'b1;
              o_rsp_valid <= 1'b1;
            end else begin
              cur       <= i_req;
              second    <= 1'b0;
              o_rsp_err <= 1'b0;
              phase_cnt <= SETUP_CYC;
              state     <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          phase_cnt <= phase_cnt - 4'h1;
          if (phase_cnt == 4'h1) begin
            phase_cnt <= STROBE_CYC;
            state     <= ST_STRB;
          end
        end
        ST_STRB: begin
          phase_cnt <= phase_cnt - 4'h1;
          if (phase_cnt == 4'h1) begin
            phase_cnt <= HOLD_CYC;
            state     <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          phase_cnt <= phase_cnt - 4'h1;
          if (phase_cnt == 4'h1) begin
            // Output enable lags the state by a clock and the byte lags
            // three more in the synchroniser, so it is taken at hold end
            if (!is_wr(cur.op)) begin
              o_rsp_data <= sync3;
            end
            if (is_two(cur.op) && !second) begin
              second    <= 1'b1;
              phase_cnt <= SETUP_CYC;
              state     <= ST_SETUP;
            end else if (is_two(cur.op)) begin
              tmr_load  <= 1'b1;
              tmr_count <= (cur.op == OP_ERASE) ? TW'(ERASE_CYC)
                                                : TW'(PROG_CYC);
              state     <= ST_WAIT;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_WAIT: begin
          if (tmr_done) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          o_rsp_valid <= 1'b1;
          state       <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Flash pins
  // ************************************************************
  // Address held over the whole cycle so it is valid at either latch edge
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_pins       <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1,
                        byte_addr: '0};
      o_data_io_o  <= '0;
      o_data_io_oe <= 1'b0;
    end else begin
      o_pins.byte_addr <= cur.byte_addr;
      o_pins.chip_sel_n <= !(state == ST_SETUP || state == ST_STRB ||
                             state == ST_HOLD);
      // Read strobes output enable; writes keep it high throughout
      o_pins.out_en_n <= !(state == ST_STRB && !is_wr(cur.op));
      // Strobe falls after setup and rises with data still driven
      o_pins.wr_en_n <= !(state == ST_STRB && is_wr(cur.op));
      o_data_io_oe <= is_wr(cur.op) && (state == ST_SETUP ||
                      state == ST_STRB || state == ST_HOLD);
      // First cycle carries the setup command, second the operand (cmd1 again for erase); a single write carries wdata
      o_data_io_o <= (is_two(cur.op) && !second) ? cur.cmd1
                   : (cur.op == OP_ERASE) ? cur.cmd1 : cur.wdata;
    end
  end

  pulse_timer #(
    .CNT_W (TW)
  ) u_timer (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .o_busy    (tmr_busy),
    .o_done    (tmr_done)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  chk_oe_during_write: assert property (@(posedge i_sys_clk)
    disable iff (i_reset) !o_pins.wr_en_n |-> o_pins.out_en_n)
    else $error("output enable low during write strobe");
  chk_cs_with_write: assert property (@(posedge i_sys_clk)
    disable iff (i_reset) !o_pins.wr_en_n |-> !o_pins.chip_sel_n)
    else $error("write strobe without chip select");
  chk_no_bus_clash: assert property (@(posedge i_sys_clk)
    disable iff (i_reset) o_data_io_oe |-> o_pins.out_en_n)
    else $error("host drives data while device may drive");
  chk_vpp_for_write: assert property (@(posedge i_sys_clk)
    disable iff (i_reset) !o_pins.wr_en_n |-> o_vpp_high)
    else $error("write strobe without programming voltage");
  chk_data_at_rise: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    (!$past(o_pins.wr_en_n) && o_pins.wr_en_n) |-> o_data_io_oe)
    else $error("data released before strobe rose");
  chk_addr_stable: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    !o_pins.wr_en_n |-> $stable(o_pins.byte_addr))
    else $error("address moved during write strobe");
  chk_oe_in_pulse: assert property (@(posedge i_sys_clk)
    disable iff (i_reset) tmr_busy |-> (o_pins.out_en_n && o_pins.wr_en_n))
    else $error("bus active during a pulse");
  chk_two_cycles: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    (state == ST_WAIT && $past(state) == ST_HOLD) |-> second)
    else $error("pulse wait began after one write");
  chk_prog_wait: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    (tmr_load && cur.op == OP_PROG) |-> tmr_count == TW'(PROG_CYC))
    else $error("wrong program pulse length");
  cov_read: cover property (@(posedge i_sys_clk)
    o_rsp_valid && !o_rsp_err && cur.op == OP_READ);
  cov_prog: cover property (@(posedge i_sys_clk)
    tmr_done && cur.op == OP_PROG);
  cov_erase: cover property (@(posedge i_sys_clk)
    tmr_load && cur.op == OP_ERASE);
  cov_refused: cover property (@(posedge i_sys_clk)
    o_rsp_valid && o_rsp_err);

endmodule
`default_nettype wire

// File: design/pulse_timer.sv
// Purpose: down counter that times one program or erase pulse
// Assumes: load and run come from the same clock domain
// Notes:   done is a one-cycle pulse when the count expires
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
  parameter int CNT_W = 20
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_count,
  output var  logic             o_busy,
  output var  logic             o_done
);

  logic [CNT_W-1:0] remain;

  // Count down once loaded; a reload restarts the wait
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      remain <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_load) begin
        remain <= i_count;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (remain <= CNT_W'(1)) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          remain <= remain - CNT_W'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: inc/flash_host_pkg.sv
// Purpose: shared constants and types for the bulk-erase flash host controller
// Assumes: 50 MHz system clock, flash pins driven by the host as plain levels
// Notes:   command codes are not fixed here; the user supplies them per request
package flash_host_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ         = 50;
  localparam int PROG_PULSE_US   = 10;
  localparam int ERASE_PULSE_MS  = 10;
  localparam int PROG_PULSE_CYC  = PROG_PULSE_US * CLK_MHZ;
  localparam int ERASE_PULSE_CYC = ERASE_PULSE_MS * 1000 * CLK_MHZ;
  // Phase lengths of one bus cycle, in system clocks (20 ns each)
  localparam logic [3:0] SETUP_CYC  = 4'h2;
  localparam logic [3:0] STROBE_CYC = 4'h4;
  localparam logic [3:0] HOLD_CYC   = 4'h2;

  // ************************************************************
  // Operation kinds on the user port
  // ************************************************************
  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_WRITE = 2'b01,
    OP_PROG  = 2'b10,
    OP_ERASE = 2'b11
  } op_type;

  typedef struct packed {
    op_type              op;
    logic [ADDR_W-1:0]   byte_addr;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   cmd1;
  } req_type;

  typedef struct packed {
    logic                chip_sel_n;
    logic                out_en_n;
    logic                wr_en_n;
    logic [ADDR_W-1:0]   byte_addr;
  } pins_type;

endpackage
